// ==== scl_pkg.sv ====
// Constants for the strap configuration latch
package scl_pkg;
	localparam int STRAP_W = 13;
	// Strap vector bit positions
	localparam int POS_STARTUP = 0;
	localparam int POS_INBAND = 1;
	localparam int POS_CLKMODE = 2;
	localparam int POS_SPEED = 3;
	localparam int POS_XMII_LO = 4;
	localparam int POS_XMII_HI = 5;
	localparam int POS_MGMT_LO = 6;
	localparam int POS_MGMT_HI = 7;
	localparam int POS_PHY_LO = 8;
	localparam int POS_PHY_HI = 9;
	localparam int POS_TEST0 = 10;
	localparam int POS_TEST1 = 11;
	localparam int POS_SPARE = 12;
	// Defaults held until the first latch event
	localparam logic [12:0] STRAP_RESET = 13'h010F;
	localparam logic [1:0] XMII_MII = 2'h0;
	localparam logic [1:0] XMII_RMII = 2'h1;
	localparam logic [1:0] XMII_RGMII = 2'h3;
	localparam logic [1:0] MGMT_MIIM = 2'h0;
	localparam logic [1:0] MGMT_I2C = 2'h1;
	localparam logic [1:0] PHY_ANEG_EEE = 2'h1;
	localparam logic [1:0] PHY_FORCE_MDIX = 2'h2;
	localparam logic [1:0] PHY_FORCE_MDI = 2'h3;
	// Latch request is raised for one cycle when this many cycles have passed since reset release
	localparam logic [1:0] REL_CYCLES = 2'h2;
endpackage

// ==== scl_sync.sv ====
// Two-flop synchroniser for a bank of strap pins
`timescale 1ns/10ps
module scl_sync
#(
	parameter int W = 1
)
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			dout     <= '0;
		end
		else
		begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule

// ==== scl_strap_latch.sv ====
// Strap pin capture and mode decode for the three-port switch
`timescale 1ns/10ps
module scl_strap_latch
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       powerup_done,
	input  wire logic       soft_reset_done,
	input  wire logic       powerdown_exit,
	input  wire logic       startup_switch_strap,
	input  wire logic       inband_mgmt_strap,
	input  wire logic       port3_clock_mode_strap,
	input  wire logic       port3_speed_strap,
	input  wire logic [1:0] port3_xmii_strap,
	input  wire logic [1:0] mgmt_if_strap,
	input  wire logic [1:0] phy_cfg_strap,
	input  wire logic [1:0] test_strap,
	input  wire logic       start_switch_bit,
	output logic            forward_enable,
	output logic            frame_based_management,
	output logic            mii_mac_mode,
	output logic            ref_clock_output_en,
	output logic            ref_clock_input_sel,
	output logic            rgmii_inband_status,
	output logic            port3_speed_1000,
	output logic [1:0]      port3_xmii_mode,
	output logic            port3_xmii_reserved,
	output logic            mgmt_miim_sel,
	output logic            mgmt_i2c_sel,
	output logic            mgmt_spi_sel,
	output logic            phy_aneg_enable,
	output logic            phy_eee_enable,
	output logic            phy_auto_mdix,
	output logic            phy_force_100_fd,
	output logic            phy_mdix_sel,
	output logic            phy_cfg_reserved,
	output logic            factory_test,
	output logic            strap_latched
);
	logic [12:0] pin_raw;
	logic [12:0] pin_sync;
	logic [2:0]  evt_sync;
	logic [2:0]  evt_prev_reg;
	logic [1:0]  rel_cnt_reg;
	logic [12:0] strap_reg;
	logic        latch_now;
	logic        startup_hold_reg;

	assign pin_raw = {1'b0, test_strap, phy_cfg_strap, mgmt_if_strap, port3_xmii_strap,
		port3_speed_strap, port3_clock_mode_strap, inband_mgmt_strap, startup_switch_strap};

	// Pins and event strobes come from outside the clock domain
	scl_sync #(.W(13)) u_pin_sync
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (pin_raw),
		.dout  (pin_sync)
	);

	scl_sync #(.W(3)) u_evt_sync
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   ({powerdown_exit, soft_reset_done, powerup_done}),
		.dout  (evt_sync)
	);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			evt_prev_reg <= 3'h7;
		else
			evt_prev_reg <= evt_sync;
	end

	// Reset release: wait until the pin synchroniser holds real levels
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rel_cnt_reg <= 2'h0;
		else if (rel_cnt_reg != scl_pkg::REL_CYCLES + 2'h1)
			rel_cnt_reg <= rel_cnt_reg + 2'h1;
	end

	// Rising edges of completion strobes plus reset release
	assign latch_now = (|(evt_sync & ~evt_prev_reg))
		| (rel_cnt_reg == scl_pkg::REL_CYCLES);

	// Held between events so later LED and data activity cannot disturb it
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			strap_reg <= scl_pkg::STRAP_RESET;
		else if (latch_now)
			strap_reg <= pin_sync;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			strap_latched <= 1'b0;
		else if (latch_now)
			strap_latched <= 1'b1;
	end

	// Once software starts the switch it stays started until the next latch
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			startup_hold_reg <= 1'b0;
		else if (start_switch_bit)
			startup_hold_reg <= 1'b1;
		else if (latch_now)
			startup_hold_reg <= 1'b0;
	end

	// No forwarding during reset settling or before start when strapped 0
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			forward_enable <= 1'b0;
		else
			forward_enable <= strap_latched
				& (strap_reg[scl_pkg::POS_STARTUP] | startup_hold_reg);
	end

	// Either test pin alone leaves normal operation
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			factory_test <= 1'b0;
		else
			factory_test <= |strap_reg[scl_pkg::POS_TEST1:scl_pkg::POS_TEST0];
	end

	// Exactly one management interface is selected; any upper bit picks SPI
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mgmt_miim_sel <= 1'b1;
			mgmt_i2c_sel  <= 1'b0;
			mgmt_spi_sel  <= 1'b0;
		end
		else
		begin
			mgmt_spi_sel  <= strap_reg[scl_pkg::POS_MGMT_HI];
			mgmt_miim_sel <= strap_reg[scl_pkg::POS_MGMT_HI:scl_pkg::POS_MGMT_LO] == scl_pkg::MGMT_MIIM;
			mgmt_i2c_sel  <= strap_reg[scl_pkg::POS_MGMT_HI:scl_pkg::POS_MGMT_LO] == scl_pkg::MGMT_I2C;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frame_based_management <= 1'b0;
			mii_mac_mode           <= 1'b1;
			ref_clock_output_en    <= 1'b0;
			ref_clock_input_sel    <= 1'b1;
			rgmii_inband_status    <= 1'b1;
			port3_speed_1000       <= 1'b0;
			port3_xmii_mode        <= scl_pkg::XMII_MII;
			port3_xmii_reserved    <= 1'b0;
			phy_aneg_enable        <= 1'b1;
			phy_eee_enable         <= 1'b1;
			phy_auto_mdix          <= 1'b1;
			phy_force_100_fd       <= 1'b0;
			phy_mdix_sel           <= 1'b0;
			phy_cfg_reserved       <= 1'b0;
		end
		else
		begin
			frame_based_management <= ~strap_reg[scl_pkg::POS_INBAND];
			mii_mac_mode        <= strap_reg[scl_pkg::POS_CLKMODE];
			ref_clock_output_en <= ~strap_reg[scl_pkg::POS_CLKMODE];
			ref_clock_input_sel <= strap_reg[scl_pkg::POS_CLKMODE];
			rgmii_inband_status <= strap_reg[scl_pkg::POS_CLKMODE];
			// Speed taken as strapped; a bad MII/RMII at 1000 is the board's fault
			port3_speed_1000 <= ~strap_reg[scl_pkg::POS_SPEED];
			port3_xmii_mode  <= strap_reg[scl_pkg::POS_XMII_HI:scl_pkg::POS_XMII_LO];
			port3_xmii_reserved <= strap_reg[scl_pkg::POS_XMII_HI:scl_pkg::POS_XMII_LO] == 2'h2;
			case (strap_reg[scl_pkg::POS_PHY_HI:scl_pkg::POS_PHY_LO])
				scl_pkg::PHY_ANEG_EEE:
				begin
					phy_aneg_enable  <= 1'b1;
					phy_eee_enable   <= 1'b1;
					phy_auto_mdix    <= 1'b1;
					phy_force_100_fd <= 1'b0;
					phy_mdix_sel     <= 1'b0;
					phy_cfg_reserved <= 1'b0;
				end
				scl_pkg::PHY_FORCE_MDIX, scl_pkg::PHY_FORCE_MDI:
				begin
					phy_aneg_enable  <= 1'b0;
					phy_eee_enable   <= 1'b0;
					phy_auto_mdix    <= 1'b0;
					phy_force_100_fd <= 1'b1;
					phy_mdix_sel     <= ~strap_reg[scl_pkg::POS_PHY_LO];
					phy_cfg_reserved <= 1'b0;
				end
				default:
				begin
					// Reserved code keeps autoneg so the link can still come up
					phy_aneg_enable  <= 1'b1;
					phy_eee_enable   <= 1'b0;
					phy_auto_mdix    <= 1'b1;
					phy_force_100_fd <= 1'b0;
					phy_mdix_sel     <= 1'b0;
					phy_cfg_reserved <= 1'b1;
				end
			endcase
		end
	end
endmodule

// ==== scl_pull_model.sv ====
// Board pull resistors that set the strap pin levels
`timescale 1ns/10ps
module scl_pull_model
(
	input  wire logic [12:0] pull,
	output logic      [12:0] pin
);
	// Every strap has its own resistor, so no pin floats; the bench picks the levels
	assign pin = pull;
endmodule

// ==== scl_strap_latch_chk.sv ====
// Concurrent checks on the decoded strap settings
`timescale 1ns/10ps
module scl_strap_latch_chk
(
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       powerup_done,
	input wire logic       soft_reset_done,
	input wire logic       powerdown_exit,
	input wire logic       start_switch_bit,
	input wire logic       forward_enable,
	input wire logic       mii_mac_mode,
	input wire logic       ref_clock_output_en,
	input wire logic       ref_clock_input_sel,
	input wire logic       rgmii_inband_status,
	input wire logic [1:0] port3_xmii_mode,
	input wire logic       port3_xmii_reserved,
	input wire logic       mgmt_miim_sel,
	input wire logic       mgmt_i2c_sel,
	input wire logic       mgmt_spi_sel,
	input wire logic       phy_aneg_enable,
	input wire logic       phy_eee_enable,
	input wire logic       phy_auto_mdix,
	input wire logic       phy_force_100_fd,
	input wire logic       phy_mdix_sel,
	input wire logic       phy_cfg_reserved,
	input wire logic       factory_test,
	input wire logic       strap_latched
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_ref_clk_dir: assert property (ref_clock_output_en != ref_clock_input_sel) else $error("clock dir");
	a_mac_inband: assert property (mii_mac_mode == rgmii_inband_status && mii_mac_mode != ref_clock_output_en)
		else $error("mac mode");
	a_mgmt_onehot: assert property ($onehot({mgmt_miim_sel, mgmt_i2c_sel, mgmt_spi_sel})) else $error("mgmt");
	a_xmii_rsv: assert property (port3_xmii_reserved == (port3_xmii_mode == 2'h2)) else $error("xmii");
	a_phy_forced: assert property (phy_force_100_fd |-> !phy_aneg_enable && !phy_auto_mdix && !phy_eee_enable)
		else $error("phy forced");
	a_phy_aneg: assert property (!phy_force_100_fd |-> phy_aneg_enable && !phy_mdix_sel && phy_eee_enable != phy_cfg_reserved)
		else $error("phy aneg");
	// Start bit sets the hold flop, which reaches forwarding one edge later
	a_start_bit: assert property ($rose(start_switch_bit) && strap_latched |-> ##2 forward_enable) else $error("start");
	// Quiet event lines must leave the latched settings alone
	a_hold_cfg: assert property ((strap_latched && !(powerup_done || soft_reset_done || powerdown_exit)) [*5]
		|=> $stable({mii_mac_mode, port3_xmii_mode, phy_mdix_sel, factory_test})) else $error("hold");
	cover property (port3_xmii_reserved);
	cover property (mgmt_spi_sel);
	cover property (phy_cfg_reserved);
	cover property (phy_force_100_fd && phy_mdix_sel);
endmodule
bind scl_strap_latch scl_strap_latch_chk i_scl_strap_latch_chk (.*);

// ==== scl_strap_latch_tb.sv ====
// Testbench for the strap configuration latch
`timescale 1ns/10ps
module scl_strap_latch_tb;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  ev = 3'h0;
	logic        start = 1'b0;
	logic [12:0] pull = 13'h0000;
	logic [12:0] p;
	logic [20:0] o;
	int          failures = 0;
	int          n_checks = 0;
	int          i;
	scl_pull_model i_scl_pull_model (.pull(pull), .pin(p));
	scl_strap_latch i_scl_strap_latch (.mclk(mclk), .rst_n(rst_n), .powerup_done(ev[0]), .soft_reset_done(ev[1]),
		.powerdown_exit(ev[2]), .startup_switch_strap(p[0]), .inband_mgmt_strap(p[1]), .port3_clock_mode_strap(p[2]),
		.port3_speed_strap(p[3]), .port3_xmii_strap(p[5:4]), .mgmt_if_strap(p[7:6]), .phy_cfg_strap(p[9:8]),
		.test_strap(p[11:10]), .start_switch_bit(start), .forward_enable(o[0]), .frame_based_management(o[1]),
		.mii_mac_mode(o[2]), .ref_clock_output_en(o[3]), .ref_clock_input_sel(o[4]), .rgmii_inband_status(o[5]),
		.port3_speed_1000(o[6]), .port3_xmii_mode(o[8:7]), .port3_xmii_reserved(o[9]), .mgmt_miim_sel(o[10]),
		.mgmt_i2c_sel(o[11]), .mgmt_spi_sel(o[12]), .phy_aneg_enable(o[13]), .phy_eee_enable(o[14]),
		.phy_auto_mdix(o[15]), .phy_force_100_fd(o[16]), .phy_mdix_sel(o[17]), .phy_cfg_reserved(o[18]),
		.factory_test(o[19]), .strap_latched(o[20]));
	initial
		forever #4 mclk = ~mclk;
	// Each two-bit field but the test pair takes the case code, so four cases walk every code
	// Test pins stay at normal, and MII or RMII always gets the 100 Mb/s strap
	function automatic logic [12:0] vec(input int k);
		logic [1:0] t;
		t = k[1:0];
		return {1'b0, 2'h0, t, t, t, ~t[1] | t[0], t[1], t[0], t[1]};
	endfunction
	function automatic logic [20:0] exp(input logic [12:0] v, input logic s);
		logic [1:0] c;
		c = v[9:8];
		return {1'b1, |v[11:10], c == 2'h0, c == 2'h2, c[1], !c[1], c == 2'h1, !c[1], v[7], v[7:6] == 2'h1,
			v[7:6] == 2'h0, v[5:4] == 2'h2, v[5:4], !v[3], v[2], v[2], !v[2], v[2], !v[1], v[0] | s};
	endfunction
	task automatic chk(input logic [20:0] g, input logic [20:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Pins settle before release, as the latch at release loads them on the third clock edge after release
	task automatic rst(input int k);
		int w;
		rst_n = 1'b0;
		pull = vec(k);
		cyc(16);
		rst_n = 1'b1;
		for (w = 0; w < 10 && o[20] !== 1'b1; w++)
			cyc(1);
		if (w == 10)
		begin
			failures++;
			tally_and_finish();
		end
		cyc(3);
		chk(o, exp(pull, 1'b0));
	endtask
	initial
	begin
		rst(2);
		for (i = 0; i < 4; i++)
		begin
			pull = vec(i);
			cyc(1);
			ev[i % 3] = 1'b1;
			cyc(2);
			ev[i % 3] = 1'b0;
			cyc(6);
			chk(o, exp(pull, 1'b0));
			if (pull[0] == 1'b0)
			begin
				start = 1'b1;
				cyc(1);
				start = 1'b0;
				cyc(2);
				chk(o, exp(pull, 1'b1));
			end
		end
		pull = vec(0);
		cyc(10);
		chk(o, exp(vec(3), 1'b0));
		rst(1);
		tally_and_finish();
	end
endmodule
